// ---- awd_pkg.sv ----
// Package: register map, field layout and types of the activity wakeup detector
// Notes on behaviour
// - An axis detects only when its delta is strictly above its threshold.
// - X, Y and Z each hold an independent unsigned 6-bit threshold, 0 to 63.
// - With counting enabled an axis wakes only once its count plus one detections accumulate.
// - Each axis has a 6-bit count holding required events minus one.
// - Data field at 0x13 reaches the shadow chosen by select; 000 none, 001 X threshold.
// - Select 010/011 Y/Z threshold, 100 none, 101/110/111 X/Y/Z detection counts.
// - Combine bit 6 clear: wakeup when any active axis meets threshold and count.
// - Combine bit 6 set: wakeup only when every active axis meets both.
// - Axes with power-down bit set in 0x10 bits 6:4 leave the combination.
// - Delta-method bit 7 clear: delta is current minus previous sample.
// - Delta-method bit 7 set: delta is current minus baseline captured on entry.
// - A selected 6-bit slice of the 11-bit delta is compared, with clamping.
`default_nettype none
package awd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PWR = 8'h10;
  localparam logic [7:0] IDX_THC = 8'h13;
  localparam logic [7:0] IDX_CFG = 8'h14;
  localparam logic [7:0] IDX_WATCH = 8'h15;
  localparam logic [7:0] IDX_STAT = 8'h16;
  // Field positions
  localparam int PWR_PD_LSB = 4;
  localparam int THC_MODE_BIT = 7;
  localparam int THC_ANDOR_BIT = 6;
  localparam int CFG_RESTART_BIT = 7;
  localparam int CFG_MUX_LSB = 4;
  localparam int CFG_CNTEN_BIT = 3;
  localparam int STAT_WAKE_BIT = 0;
  localparam int STAT_MET_LSB = 1;
  localparam int STAT_REF_BIT = 4;
  // Reset values
  localparam logic [2:0] PD_RST = 3'h0;
  localparam logic [5:0] SHADOW_RST = 6'h00;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [2:0] MUX_RST = 3'h0;
  // Widths
  localparam int TH_W = 6;
  localparam int DELTA_W = 11;
  localparam int AXES = 3;
  localparam int SHADOWS = 6;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [2:0] MUX_TOP = 3'h5;

  typedef enum logic {PH_IDLE, PH_WAIT} awd_phase_e;
endpackage
`default_nettype wire

// ---- awd_detector.sv ----
// Activity wakeup detector with AHB-Lite register slave
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module awd_detector #(
  parameter int SAMPLE_W = 12,
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SAMPLE_STB,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_X,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_Y,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_Z,
  output logic WAKE,
  output logic [2:0] AXIS_MET
);
  typedef logic signed [SAMPLE_W-1:0] awd_smp_t;
  localparam logic [awd_pkg::DELTA_W-1:0] DELTA_MAX = {awd_pkg::DELTA_W{1'b1}};

  typedef struct packed {
    awd_pkg::awd_phase_e ph;
    logic [7:0] addr;
    logic wr;
    logic [31:0] hrdata;
    logic hready;
    logic [2:0] pd;
    logic mode;
    logic and_or;
    logic [awd_pkg::SHADOWS-1:0][awd_pkg::TH_W-1:0] shadow;
    logic [2:0] sel;
    logic [2:0] mux;
    logic cnten;
    logic watch_en;
    logic have_ref;
    logic [awd_pkg::AXES-1:0][SAMPLE_W-1:0] prev;
    logic [awd_pkg::AXES-1:0][SAMPLE_W-1:0] base;
    logic [awd_pkg::AXES-1:0][5:0] cnt;
    logic [2:0] met;
    logic wake_sticky;
    logic wake;
  } awd_state_s;

  awd_state_s s_r;
  awd_state_s s_nxt;
  awd_smp_t cur [awd_pkg::AXES];

  assign cur[0] = SAMPLE_X;
  assign cur[1] = SAMPLE_Y;
  assign cur[2] = SAMPLE_Z;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Select code to shadow slot: {valid, slot}
  function automatic logic [3:0] shadow_slot(input logic [2:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      3'h1: r = 4'h8;
      3'h2: r = 4'h9;
      3'h3: r = 4'hA;
      3'h5: r = 4'hB;
      3'h6: r = 4'hC;
      3'h7: r = 4'hD;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Magnitude of a difference, saturated to the delta width
  function automatic logic [awd_pkg::DELTA_W-1:0] delta_mag(input awd_smp_t a, input awd_smp_t b);
    logic signed [SAMPLE_W:0] d;
    logic [SAMPLE_W:0] m;
    d = {a[SAMPLE_W-1], a} - {b[SAMPLE_W-1], b};
    m = d[SAMPLE_W] ? (SAMPLE_W + 1)'(-d) : d;
    if (m > (SAMPLE_W + 1)'(DELTA_MAX)) begin
      delta_mag = DELTA_MAX;
    end else begin
      delta_mag = m[awd_pkg::DELTA_W-1:0];
    end
  endfunction

  // Slice compare: true when slice exceeds threshold or delta overflows slice
  function automatic logic slice_detect(input logic [awd_pkg::DELTA_W-1:0] mag, input logic [2:0] mux,
                                        input logic [5:0] th);
    logic [2:0] sh;
    logic [awd_pkg::DELTA_W-1:0] shifted;
    logic over;
    sh = (mux > awd_pkg::MUX_TOP) ? awd_pkg::MUX_TOP : mux;
    shifted = mag >> sh;
    over = |shifted[awd_pkg::DELTA_W-1:awd_pkg::TH_W];
    slice_detect = over || (shifted[awd_pkg::TH_W-1:0] > th);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [3:0] slot;
    logic [31:0] rd;
    logic restart;
    logic det;
    logic [2:0] met;
    logic [2:0] active;
    logic any_met;
    logic all_met;
    awd_smp_t refv;
    slot = 4'h0;
    rd = 32'h0000_0000;
    restart = 1'b0;
    det = 1'b0;
    met = 3'h0;
    active = 3'h0;
    any_met = 1'b0;
    all_met = 1'b0;
    refv = '0;
    s_nxt = s_r;
    s_nxt.wake = 1'b0;

    // Bus: one wait state on every transfer
    case (s_r.ph)
      awd_pkg::PH_IDLE: begin
        if (HSEL && HTRANS[1] && HREADY) begin
          s_nxt.addr = 8'(HADDR >> 2);
          s_nxt.wr = HWRITE;
          s_nxt.ph = awd_pkg::PH_WAIT;
          s_nxt.hready = 1'b0;
        end
      end
      awd_pkg::PH_WAIT: begin
        s_nxt.ph = awd_pkg::PH_IDLE;
        s_nxt.hready = 1'b1;
        slot = shadow_slot(s_r.sel);
        if (s_r.wr) begin
          case (s_r.addr)
            awd_pkg::IDX_PWR: s_nxt.pd = HWDATA[awd_pkg::PWR_PD_LSB+:3];
            awd_pkg::IDX_THC: begin
              s_nxt.mode = HWDATA[awd_pkg::THC_MODE_BIT];
              s_nxt.and_or = HWDATA[awd_pkg::THC_ANDOR_BIT];
              if (slot[3]) begin
                s_nxt.shadow[slot[2:0]] = HWDATA[awd_pkg::TH_W-1:0];
              end
            end
            awd_pkg::IDX_CFG: begin
              s_nxt.sel = HWDATA[2:0];
              s_nxt.cnten = HWDATA[awd_pkg::CFG_CNTEN_BIT];
              s_nxt.mux = HWDATA[awd_pkg::CFG_MUX_LSB+:3];
              restart = HWDATA[awd_pkg::CFG_RESTART_BIT];
            end
            awd_pkg::IDX_WATCH: begin
              s_nxt.watch_en = HWDATA[0];
              if (HWDATA[0] && !s_r.watch_en) begin
                restart = 1'b1;
              end
            end
            awd_pkg::IDX_STAT: begin
              if (HWDATA[awd_pkg::STAT_WAKE_BIT]) begin
                s_nxt.wake_sticky = 1'b0;
              end
            end
            default: ;
          endcase
        end else begin
          case (s_r.addr)
            awd_pkg::IDX_PWR: rd[awd_pkg::PWR_PD_LSB+:3] = s_r.pd;
            awd_pkg::IDX_THC: begin
              rd[awd_pkg::THC_MODE_BIT] = s_r.mode;
              rd[awd_pkg::THC_ANDOR_BIT] = s_r.and_or;
              if (slot[3]) begin
                rd[awd_pkg::TH_W-1:0] = s_r.shadow[slot[2:0]];
              end
            end
            awd_pkg::IDX_CFG: begin
              rd[2:0] = s_r.sel;
              rd[awd_pkg::CFG_CNTEN_BIT] = s_r.cnten;
              rd[awd_pkg::CFG_MUX_LSB+:3] = s_r.mux;
            end
            awd_pkg::IDX_WATCH: rd[0] = s_r.watch_en;
            awd_pkg::IDX_STAT: begin
              rd[awd_pkg::STAT_WAKE_BIT] = s_r.wake_sticky;
              rd[awd_pkg::STAT_MET_LSB+:3] = s_r.met;
              rd[awd_pkg::STAT_REF_BIT] = s_r.have_ref;
            end
            default: rd = 32'h0000_0000;
          endcase
          s_nxt.hrdata = rd;
        end
      end
      default: begin
        s_nxt.ph = awd_pkg::PH_IDLE;
        s_nxt.hready = 1'b1;
      end
    endcase

    if (restart) begin
      s_nxt.have_ref = 1'b0;
      s_nxt.cnt = '0;
      s_nxt.met = 3'h0;
    end else if (s_r.watch_en && SAMPLE_STB) begin
      if (!s_r.have_ref) begin
        for (int a = 0; a < awd_pkg::AXES; a++) begin
          s_nxt.prev[a] = cur[a];
          s_nxt.base[a] = cur[a];
        end
        s_nxt.have_ref = 1'b1;
      end else begin
        for (int a = 0; a < awd_pkg::AXES; a++) begin
          refv = s_r.mode ? awd_smp_t'(s_r.base[a]) : awd_smp_t'(s_r.prev[a]);
          det = slice_detect(delta_mag(cur[a], refv), s_r.mux, s_r.shadow[a]);
          met[a] = det && (!s_r.cnten || (s_r.cnt[a] >= s_r.shadow[a+3]));
          if (det && s_r.cnt[a] != awd_pkg::CNT_MAX) begin
            s_nxt.cnt[a] = s_r.cnt[a] + 6'h01;
          end
          s_nxt.prev[a] = cur[a];
        end
        active = ~s_r.pd;
        any_met = |(met & active);
        all_met = (&(met | ~active)) && (|active);
        s_nxt.met = met;
        if (s_r.and_or ? all_met : any_met) begin
          s_nxt.wake = 1'b1;
          s_nxt.wake_sticky = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_r.ph <= awd_pkg::PH_IDLE;
      s_r.addr <= 8'h00;
      s_r.wr <= 1'b0;
      s_r.hrdata <= 32'h0000_0000;
      s_r.hready <= 1'b1;
      s_r.pd <= awd_pkg::PD_RST;
      s_r.mode <= 1'b0;
      s_r.and_or <= 1'b0;
      s_r.shadow <= {awd_pkg::SHADOWS{awd_pkg::SHADOW_RST}};
      s_r.sel <= awd_pkg::SEL_RST;
      s_r.mux <= awd_pkg::MUX_RST;
      s_r.cnten <= 1'b0;
      s_r.watch_en <= 1'b0;
      s_r.have_ref <= 1'b0;
      s_r.prev <= '0;
      s_r.base <= '0;
      s_r.cnt <= '0;
      s_r.met <= 3'h0;
      s_r.wake_sticky <= 1'b0;
      s_r.wake <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign HRDATA = s_r.hrdata;
  assign HREADYOUT = s_r.hready;
  assign HRESP = 1'b0;
  assign WAKE = s_r.wake;
  assign AXIS_MET = s_r.met;
endmodule
`default_nettype wire

// ---- awd_detector_asserts.sv ----
// Port-level checker for the activity wakeup detector
`timescale 1ns/10ps
`default_nettype none
module awd_detector_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic SAMPLE_STB,
  input wire logic WAKE,
  input wire logic [2:0] AXIS_MET
);
  logic a_wr_r;
  logic [7:0] a_idx_r;
  logic [2:0] off_r;
  logic and_r;
  logic watch_r;
  ////////////////////////////////////////////////////////////
  // Mirror of the mode bits written over the bus
  always_ff @(posedge CLK) begin
    if (RST) begin
      a_wr_r <= 1'b0;
      a_idx_r <= 8'h00;
      off_r <= 3'h0;
      and_r <= 1'b0;
      watch_r <= 1'b0;
    end else if (HSEL && HTRANS[1] && HREADY && HREADYOUT) begin
      a_wr_r <= HWRITE;
      a_idx_r <= HADDR[9:2];
    end else if (!HREADYOUT && a_wr_r) begin
      a_wr_r <= 1'b0;
      if (a_idx_r == awd_pkg::IDX_PWR) off_r <= HWDATA[6:4];
      if (a_idx_r == awd_pkg::IDX_THC) and_r <= HWDATA[6];
      if (a_idx_r == awd_pkg::IDX_WATCH) watch_r <= HWDATA[0];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_take;
    HSEL && HTRANS[1] && HREADY && HREADYOUT;
  endsequence
  sequence s_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  ready_wait_a: assert property (s_take |=> s_wait)
    else $error("bus wait state wrong");
  rdata_hold_a: assert property ($past(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data moved");
  wake_cause_a: assert property (WAKE |-> $past(SAMPLE_STB) && (AXIS_MET & ~off_r) != 3'h0)
    else $error("wake without met axis");
  or_fire_a: assert property ($past(SAMPLE_STB) && watch_r && !and_r && (AXIS_MET & ~off_r) != 3'h0 |-> WAKE)
    else $error("any-axis wake missing");
  and_fire_a: assert property ($past(SAMPLE_STB) && watch_r && and_r && (AXIS_MET | off_r) == 3'h7
    && off_r != 3'h7 |-> WAKE)
    else $error("all-axis wake missing");
  and_all_a: assert property (WAKE && and_r |-> (AXIS_MET | off_r) == 3'h7)
    else $error("all-axis wake too early");
  met_hold_a: assert property (!$past(SAMPLE_STB) && $past(HREADYOUT) && !$past(RST) |-> $stable(AXIS_MET))
    else $error("met flags moved alone");
  idle_quiet_a: assert property (!watch_r && !$past(watch_r) |-> !WAKE)
    else $error("wake while not watching");
endmodule
`default_nettype wire

// ---- tb_activity_wakeup_detector.sv ----
// Testbench for the activity wakeup detector
`timescale 1ns/10ps
`default_nettype none
module tb_activity_wakeup_detector;
  typedef struct {logic [5:0] th; logic [2:0] mux; logic [1:0] ctl; logic [2:0] off;
    int dx; int dy; int dz; logic [2:0] m; logic w;} awd_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hwrite = 1'b0;
  logic stb = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0;
  logic signed [11:0] sx = 12'h000;
  logic signed [11:0] sy = 12'h000;
  logic signed [11:0] sz = 12'h000;
  logic hreadyout, hresp, wake, wk;
  logic [31:0] hrdata, rd;
  logic [2:0] axis_met, mt;
  logic [1:0] ctl;
  int n_mismatch, check_count, i, k, s;
  awd_row_s rows [7] = '{'{6'h05, 3'h0, 2'h0, 3'h0, 6, 5, -3, 3'h1, 1'b1},
    '{6'h05, 3'h0, 2'h3, 3'h0, 6, 5, 9, 3'h5, 1'b0}, '{6'h05, 3'h0, 2'h3, 3'h2, 6, 5, -9, 3'h5, 1'b1},
    '{6'h3F, 3'h5, 2'h0, 3'h0, 2047, -2047, 0, 3'h0, 1'b0}, '{6'h03, 3'h2, 2'h2, 3'h0, 15, 16, -16, 3'h6, 1'b1},
    '{6'h00, 3'h0, 2'h0, 3'h7, 1, 1, 1, 3'h0, 1'b0}, '{6'h3F, 3'h0, 2'h1, 3'h0, 2047, -2047, 100, 3'h7, 1'b1}};
  awd_detector dut (.CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SAMPLE_STB(stb), .SAMPLE_X(sx), .SAMPLE_Y(sy), .SAMPLE_Z(sz), .WAKE(wake),
    .AXIS_MET(axis_met));
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {2'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task sh(input logic [2:0] sel, input logic [5:0] v);
    xfer(1'b1, awd_pkg::IDX_CFG, {29'h0, sel});
    xfer(1'b1, awd_pkg::IDX_THC, {24'h0, ctl, v});
  endtask
  task setup(input logic [5:0] th, input logic [2:0] mux, input logic [1:0] c, input logic [2:0] off,
    input logic en, input logic [5:0] cnt);
    ctl = c;
    xfer(1'b1, awd_pkg::IDX_WATCH, 32'h0);
    for (s = 1; s < 8; s++) if (s != 4) sh(3'(s), s < 4 ? th : cnt);
    xfer(1'b1, awd_pkg::IDX_CFG, {25'h0, mux, en, 3'h0});
    xfer(1'b1, awd_pkg::IDX_PWR, {25'h0, off, 4'h0});
    xfer(1'b1, awd_pkg::IDX_WATCH, 32'h1);
  endtask
  task strobe(input int x, input int y, input int z);
    @(posedge clk);
    stb <= 1'b1;
    sx <= 12'(x);
    sy <= 12'(y);
    sz <= 12'(z);
    @(posedge clk);
    stb <= 1'b0;
    #1;
    wk = wake;
    mt = axis_met;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[r]) begin
      setup(rows[r].th, rows[r].mux, rows[r].ctl, rows[r].off, 1'b0, 6'h00);
      strobe(0, 0, 0);
      chk(32'(wk), 32'h0);
      strobe(rows[r].dx, rows[r].dy, rows[r].dz);
      chk({mt & ~rows[r].off, wk}, {rows[r].m, rows[r].w});
      strobe(rows[r].dx, rows[r].dy, rows[r].dz);
      chk({mt & ~rows[r].off, wk}, rows[r].ctl[1] ? {rows[r].m, rows[r].w} : 4'h0);
      $display("row %0d done", r);
    end
    for (s = 7; s >= 0; s--) sh(3'(s), (s == 0 || s == 4) ? 6'h3F : 6'(s * 9));
    for (k = 1; k < 8; k++) begin
      if (k == 4) continue;
      xfer(1'b1, awd_pkg::IDX_CFG, 32'(k));
      xfer(1'b0, awd_pkg::IDX_THC, 32'h0);
      chk(rd, 32'({ctl, 6'(k * 9)}));
    end
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("shadow test done");
    for (k = 0; k < 2; k++) begin
      setup(6'h0A, 3'h0, 2'h0, 3'h6, 1'b1, 6'h02);
      strobe(0, 0, 0);
      for (i = 0; i < 4; i++) begin
        strobe(i % 2 ? -40 : 40, 0, 0);
        chk(32'(wk), 32'(i >= 2));
      end
    end
    $display("count test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({hreadyout, hresp, wake, axis_met}, 6'h20);
    xfer(1'b0, awd_pkg::IDX_THC, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    end_sim();
  end
endmodule
bind awd_detector awd_detector_asserts #(.ADDR_W(ADDR_W)) chk_i (.CLK, .RST, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .SAMPLE_STB, .WAKE, .AXIS_MET);
`default_nettype wire
